// [src/pdmc_pkg.sv]
// Package: register map, field positions, reset values and state types
package pdmc_pkg;

  localparam logic [31:0] ADDR_CLOCK_STOP_CONTROL = 32'hFE0A0000;
  localparam logic [31:0] ADDR_CLOCK_STOP_CLEAR = 32'hFE0A0008;
  localparam logic [31:0] ADDR_STANDBY_CONTROL = 32'hFFC00004;
  localparam logic [31:0] ADDR_STANDBY_CONTROL_SECOND = 32'hFFC00010;

  // standby_control fields
  localparam int STANDBY_SELECT_BIT = 7;
  localparam int PERIPH_PIN_HIZ_BIT = 6;
  localparam int PERIPH_PULLUP_DISABLE_BIT = 5;
  localparam int DMA_MODULE_STOP_BIT = 4;
  localparam int SERIAL2_MODULE_STOP_BIT = 3;
  localparam int TIMER_MODULE_STOP_BIT = 2;
  localparam int RTCLOCK_MODULE_STOP_BIT = 1;
  localparam int SERIAL1_MODULE_STOP_BIT = 0;

  // standby_control_second fields
  localparam int DEEP_SLEEP_SELECT_BIT = 7;
  localparam int STATUS_DRIVE_BIT = 6;
  localparam logic [7:0] STANDBY_CONTROL_SECOND_MASK = 8'hC3;

  // clock_stop_control implemented bits
  localparam int CLOCK_STOP_WIDTH = 3;

  localparam logic [7:0] STANDBY_CONTROL_RESET = 8'h00;
  localparam logic [7:0] STANDBY_CONTROL_SECOND_RESET = 8'h00;
  localparam logic [2:0] CLOCK_STOP_RESET = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PDMC_NORMAL,
    PDMC_SLEEP,
    PDMC_DEEP_SLEEP,
    PDMC_STANDBY,
    PDMC_HW_STANDBY
  } pdmc_mode_t;

  typedef enum logic [2:0] {
    PDMC_SEL_NONE,
    PDMC_SEL_CLOCK_STOP,
    PDMC_SEL_CLOCK_CLEAR,
    PDMC_SEL_STANDBY,
    PDMC_SEL_STANDBY_SECOND
  } pdmc_sel_t;

  // Outputs toward the rest of the chip
  typedef struct packed {
    logic proc_state_hi;
    logic proc_state_lo;
    logic proc_state_oe;
    logic cpu_halt;
    logic clock_generator_halt;
    logic [4:0] module_clock_stop;
    logic [2:0] clock_stop;
    logic [1:0] aux_module_stop;
    logic periph_pin_hiz;
    logic periph_pullup_en;
    logic all_pins_hiz;
    logic mem_refresh_en;
    logic mem_self_refresh;
    logic rtclock_count_en;
  } pdmc_out_t;

  typedef struct packed {
    pdmc_mode_t mode;
    logic [7:0] standby_control;
    logic [7:0] standby_control_second;
    logic [2:0] clock_stop_control;
    logic awready;
    logic wready;
    logic aw_held;
    logic [31:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    pdmc_out_t out;
  } pdmc_state_t;

  localparam pdmc_out_t OUT_RESET = '{
    proc_state_hi: 1'b1, proc_state_lo: 1'b1, proc_state_oe: 1'b1,
    cpu_halt: 1'b0, clock_generator_halt: 1'b0,
    module_clock_stop: 5'h00, clock_stop: 3'h0, aux_module_stop: 2'h0,
    periph_pin_hiz: 1'b0, periph_pullup_en: 1'b1, all_pins_hiz: 1'b0,
    mem_refresh_en: 1'b1, mem_self_refresh: 1'b0, rtclock_count_en: 1'b0
  };

  localparam pdmc_state_t STATE_RESET = '{
    mode: PDMC_NORMAL,
    standby_control: STANDBY_CONTROL_RESET,
    standby_control_second: STANDBY_CONTROL_SECOND_RESET,
    clock_stop_control: CLOCK_STOP_RESET,
    awready: 1'b1, wready: 1'b1,
    aw_held: 1'b0, awaddr: 32'h00000000,
    w_held: 1'b0, wdata: 32'h00000000, wstrb: 4'h0,
    bvalid: 1'b0, bresp: 2'h0,
    arready: 1'b1, rvalid: 1'b0, rdata: 32'h00000000, rresp: 2'h0,
    out: OUT_RESET
  };

endpackage

// [src/pdmc_power_down_mode_control.sv]
// Power-down mode controller with an AXI4-Lite register slave
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module pdmc_power_down_mode_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_instr,
  input wire logic sleep_request_n,
  input wire logic hw_standby_request_n,
  input wire logic wake_interrupt,
  input wire logic watchdog_overflow,
  input wire logic rtclock_start,
  output pdmc_pkg::pdmc_out_t ctrl
);

  pdmc_pkg::pdmc_state_t st;
  pdmc_pkg::pdmc_state_t next_st;

  // Full-address decode shared by the read and write paths
  function automatic pdmc_pkg::pdmc_sel_t reg_select(input logic [31:0] a);
    reg_select = pdmc_pkg::PDMC_SEL_NONE;
    case (a)
      pdmc_pkg::ADDR_CLOCK_STOP_CONTROL: begin
        reg_select = pdmc_pkg::PDMC_SEL_CLOCK_STOP;
      end
      pdmc_pkg::ADDR_CLOCK_STOP_CLEAR: begin
        reg_select = pdmc_pkg::PDMC_SEL_CLOCK_CLEAR;
      end
      pdmc_pkg::ADDR_STANDBY_CONTROL: begin
        reg_select = pdmc_pkg::PDMC_SEL_STANDBY;
      end
      pdmc_pkg::ADDR_STANDBY_CONTROL_SECOND: begin
        reg_select = pdmc_pkg::PDMC_SEL_STANDBY_SECOND;
      end
      default: begin
        reg_select = pdmc_pkg::PDMC_SEL_NONE;
      end
    endcase
  endfunction

  always_comb begin
    pdmc_pkg::pdmc_sel_t wsel;
    pdmc_pkg::pdmc_sel_t rsel;
    logic standby_select;
    logic deep_sleep_select;
    logic halted_all;
    logic deep;
    wsel = pdmc_pkg::PDMC_SEL_NONE;
    rsel = pdmc_pkg::PDMC_SEL_NONE;
    standby_select = 1'b0;
    deep_sleep_select = 1'b0;
    halted_all = 1'b0;
    deep = 1'b0;
    next_st = st;

    // Write channel: address and data taken independently
    if (s_axi_bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      wsel = reg_select(st.awaddr);
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = pdmc_pkg::RESP_OKAY;
      case (wsel)
        pdmc_pkg::PDMC_SEL_STANDBY: begin
          if (st.wstrb[0]) begin
            next_st.standby_control = st.wdata[7:0];
          end
        end
        pdmc_pkg::PDMC_SEL_STANDBY_SECOND: begin
          if (st.wstrb[0]) begin
            next_st.standby_control_second =
              st.wdata[7:0] & pdmc_pkg::STANDBY_CONTROL_SECOND_MASK;
          end
        end
        pdmc_pkg::PDMC_SEL_CLOCK_STOP: begin
          if (st.wstrb[0]) begin
            next_st.clock_stop_control = st.clock_stop_control |
              st.wdata[pdmc_pkg::CLOCK_STOP_WIDTH-1:0];
          end
        end
        pdmc_pkg::PDMC_SEL_CLOCK_CLEAR: begin
          if (st.wstrb[0]) begin
            next_st.clock_stop_control = st.clock_stop_control &
              ~st.wdata[pdmc_pkg::CLOCK_STOP_WIDTH-1:0];
          end
        end
        default: begin
          next_st.bresp = pdmc_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read channel
    if (s_axi_rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      rsel = reg_select(s_axi_araddr);
      next_st.rvalid = 1'b1;
      next_st.rresp = pdmc_pkg::RESP_OKAY;
      next_st.rdata = 32'h00000000;
      case (rsel)
        pdmc_pkg::PDMC_SEL_STANDBY: begin
          next_st.rdata[7:0] = st.standby_control;
        end
        pdmc_pkg::PDMC_SEL_STANDBY_SECOND: begin
          next_st.rdata[7:0] = st.standby_control_second;
        end
        pdmc_pkg::PDMC_SEL_CLOCK_STOP: begin
          next_st.rdata[pdmc_pkg::CLOCK_STOP_WIDTH-1:0] =
            st.clock_stop_control;
        end
        pdmc_pkg::PDMC_SEL_CLOCK_CLEAR: begin
          next_st.rdata = 32'h00000000;
        end
        default: begin
          next_st.rresp = pdmc_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Watchdog overflow reinitialises the registers
    if (watchdog_overflow) begin
      next_st.standby_control = pdmc_pkg::STANDBY_CONTROL_RESET;
      next_st.standby_control_second =
        pdmc_pkg::STANDBY_CONTROL_SECOND_RESET;
      next_st.clock_stop_control = pdmc_pkg::CLOCK_STOP_RESET;
    end

    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;

    // Mode sequencing
    standby_select = st.standby_control[pdmc_pkg::STANDBY_SELECT_BIT];
    deep_sleep_select = st.standby_control_second[pdmc_pkg::DEEP_SLEEP_SELECT_BIT];
    case (st.mode)
      pdmc_pkg::PDMC_NORMAL: begin
        if (!hw_standby_request_n) begin
          next_st.mode = pdmc_pkg::PDMC_HW_STANDBY;
        end else if (sleep_instr && standby_select) begin
          next_st.mode = pdmc_pkg::PDMC_STANDBY;
        end else if (sleep_instr && deep_sleep_select) begin
          next_st.mode = pdmc_pkg::PDMC_DEEP_SLEEP;
        end else if (sleep_instr) begin
          next_st.mode = pdmc_pkg::PDMC_SLEEP;
        end else if (!sleep_request_n) begin
          next_st.mode = pdmc_pkg::PDMC_SLEEP;
        end
      end
      pdmc_pkg::PDMC_SLEEP, pdmc_pkg::PDMC_DEEP_SLEEP,
      pdmc_pkg::PDMC_STANDBY: begin
        if (!hw_standby_request_n) begin
          next_st.mode = pdmc_pkg::PDMC_HW_STANDBY;
        end else if (wake_interrupt) begin
          next_st.mode = pdmc_pkg::PDMC_NORMAL;
        end
      end
      pdmc_pkg::PDMC_HW_STANDBY: begin
        next_st.mode = pdmc_pkg::PDMC_HW_STANDBY;
      end
      default: begin
        next_st.mode = pdmc_pkg::PDMC_NORMAL;
      end
    endcase
    if (watchdog_overflow && st.mode != pdmc_pkg::PDMC_HW_STANDBY) begin
      next_st.mode = pdmc_pkg::PDMC_NORMAL;
    end

    // Outputs follow the next mode and register values, except rtclock_count_en (from rtclock_start) and the watchdog status code
    halted_all = (next_st.mode == pdmc_pkg::PDMC_STANDBY) ||
                 (next_st.mode == pdmc_pkg::PDMC_HW_STANDBY);
    deep = next_st.mode == pdmc_pkg::PDMC_DEEP_SLEEP;
    next_st.out.cpu_halt = next_st.mode != pdmc_pkg::PDMC_NORMAL;
    next_st.out.clock_generator_halt = halted_all;
    // Each module clock stops on its own bit or a full halt; the DMA clock also stops in deep sleep
    next_st.out.module_clock_stop = next_st.standby_control[4:0] |
      {5{halted_all}};
    if (deep) begin
      next_st.out.module_clock_stop[pdmc_pkg::DMA_MODULE_STOP_BIT] =
        1'b1;
    end
    next_st.out.clock_stop = next_st.clock_stop_control;
    next_st.out.aux_module_stop = next_st.standby_control_second[1:0];
    next_st.out.periph_pin_hiz =
      ((next_st.mode == pdmc_pkg::PDMC_STANDBY) &&
       next_st.standby_control[pdmc_pkg::PERIPH_PIN_HIZ_BIT]) ||
      (next_st.mode == pdmc_pkg::PDMC_HW_STANDBY);
    next_st.out.periph_pullup_en =
      !next_st.standby_control[pdmc_pkg::PERIPH_PULLUP_DISABLE_BIT];
    next_st.out.all_pins_hiz =
      next_st.mode == pdmc_pkg::PDMC_HW_STANDBY;
    next_st.out.mem_self_refresh = deep ||
      (next_st.mode == pdmc_pkg::PDMC_STANDBY);
    next_st.out.mem_refresh_en = !next_st.out.mem_self_refresh &&
      (next_st.mode != pdmc_pkg::PDMC_HW_STANDBY);
    next_st.out.rtclock_count_en = rtclock_start;

    next_st.out.proc_state_oe = 1'b1;
    case (next_st.mode)
      pdmc_pkg::PDMC_SLEEP, pdmc_pkg::PDMC_DEEP_SLEEP: begin
        next_st.out.proc_state_hi = 1'b1;
        next_st.out.proc_state_lo = 1'b0;
      end
      pdmc_pkg::PDMC_STANDBY: begin
        next_st.out.proc_state_hi = 1'b0;
        next_st.out.proc_state_lo = 1'b1;
      end
      pdmc_pkg::PDMC_HW_STANDBY: begin
        next_st.out.proc_state_hi = 1'b0;
        next_st.out.proc_state_lo = 1'b1;
        next_st.out.proc_state_oe =
          next_st.standby_control_second[pdmc_pkg::STATUS_DRIVE_BIT];
      end
      default: begin
        next_st.out.proc_state_hi = 1'b0;
        next_st.out.proc_state_lo = 1'b0;
      end
    endcase
    // Hardware standby keeps its 01 status code even if a watchdog fires; the watchdog still clears the status drive bit that sets proc_state_oe
    if (watchdog_overflow && next_st.mode != pdmc_pkg::PDMC_HW_STANDBY) begin
      next_st.out.proc_state_hi = 1'b1;
      next_st.out.proc_state_lo = 1'b1;
      next_st.out.proc_state_oe = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= pdmc_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign ctrl = st.out;

endmodule
`default_nettype wire

// [test/pdmc_assertions.sv]
// Concurrent checks on the power-down controller outputs
`timescale 1ns/100ps
`default_nettype none
module pdmc_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_instr,
  input wire logic sleep_request_n,
  input wire logic hw_standby_request_n,
  input wire logic wake_interrupt,
  input wire logic watchdog_overflow,
  input wire logic rtclock_start,
  input wire pdmc_pkg::pdmc_out_t ctrl
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic run;
  logic [1:0] st;
  // Running normally with no overriding request this cycle
  assign run = !ctrl.cpu_halt && !watchdog_overflow && hw_standby_request_n;
  assign st = {ctrl.proc_state_hi, ctrl.proc_state_lo};
  enter_sleep_a: assert property (run && sleep_instr |=> ctrl.cpu_halt)
    else $error("sleep instruction ignored");
  pin_sleep_a: assert property (
    run && !sleep_instr && !sleep_request_n |=> st == 2'h2)
    else $error("sleep pin ignored");
  hw_entry_a: assert property (
    !hw_standby_request_n |=> ctrl.all_pins_hiz && ctrl.cpu_halt)
    else $error("hw standby not entered");
  hw_hold_a: assert property (ctrl.all_pins_hiz |=> ctrl.all_pins_hiz)
    else $error("hw standby left without reset");
  wake_exit_a: assert property (
    ctrl.cpu_halt && !ctrl.all_pins_hiz && wake_interrupt
    && hw_standby_request_n |=> !ctrl.cpu_halt)
    else $error("wake did not resume");
  sleep_code_a: assert property (
    ctrl.cpu_halt && !ctrl.clock_generator_halt |-> st == 2'h2)
    else $error("sleep status code wrong");
  standby_select_code_a: assert property (
    ctrl.clock_generator_halt && !ctrl.all_pins_hiz |-> st == 2'h1)
    else $error("standby status code wrong");
  standby_select_stop_a: assert property (
    ctrl.clock_generator_halt |-> ctrl.module_clock_stop == 5'h1F)
    else $error("standby left modules clocked");
  pin_hiz_a: assert property (ctrl.periph_pin_hiz |-> ctrl.cpu_halt)
    else $error("pins floated while running");
  self_ref_a: assert property (
    ctrl.mem_self_refresh |-> ctrl.cpu_halt && !ctrl.mem_refresh_en
    && ctrl.module_clock_stop[4])
    else $error("self refresh outside power-down");
  rtc_run_a: assert property (
    $past(aresetn) |-> ctrl.rtclock_count_en == $past(rtclock_start))
    else $error("rtc count enable wrong");
  cover property (run && sleep_instr ##1 !ctrl.clock_generator_halt);
  cover property (run && sleep_instr ##1 ctrl.clock_generator_halt);
  cover property (!hw_standby_request_n ##1 ctrl.all_pins_hiz);
endmodule
bind pdmc_power_down_mode_control pdmc_assertions i_chk (
  .aclk, .aresetn, .sleep_instr, .sleep_request_n, .hw_standby_request_n,
  .wake_interrupt, .watchdog_overflow, .rtclock_start, .ctrl);
`default_nettype wire

// [test/power_down_mode_control_tb_top.sv]
// Self-checking bench for the power-down mode controller
`timescale 1ns/100ps
`default_nettype none
module power_down_mode_control_tb_top;
  localparam logic [1:0] OK = pdmc_pkg::RESP_OKAY;
  localparam logic [1:0] ER = pdmc_pkg::RESP_SLVERR;
  localparam logic [31:0] A_SC = pdmc_pkg::ADDR_STANDBY_CONTROL;
  localparam logic [31:0] A_S2 = pdmc_pkg::ADDR_STANDBY_CONTROL_SECOND;
  localparam logic [31:0] A_CS = pdmc_pkg::ADDR_CLOCK_STOP_CONTROL;
  localparam logic [31:0] A_CC = pdmc_pkg::ADDR_CLOCK_STOP_CLEAR;
  logic aclk, aresetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, sleep_instr, sleep_request_n;
  logic hw_standby_request_n, wake_interrupt, watchdog_overflow;
  logic rtclock_start;
  pdmc_pkg::pdmc_out_t ctrl;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 86;
  int k;
  logic [31:0] rnd;
  logic [33:0] exp_q[$];
  logic [7:0] v, obs;
  logic [7:0] sc_t[4] = '{8'h00, 8'h00, 8'h80, 8'hC0};
  logic [7:0] s2_t[4] = '{8'h00, 8'h80, 8'h00, 8'h00};
  logic [7:0] ob_t[4] = '{8'hA1, 8'hA9, 8'h79, 8'h7D};
  assign obs = {ctrl.proc_state_hi, ctrl.proc_state_lo, ctrl.cpu_halt,
    ctrl.clock_generator_halt, ctrl.mem_self_refresh, ctrl.periph_pin_hiz,
    ctrl.all_pins_hiz, ctrl.periph_pullup_en};
  pdmc_power_down_mode_control i_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sleep_instr, .sleep_request_n, .hw_standby_request_n, .wake_interrupt,
    .watchdog_overflow, .rtclock_start, .ctrl);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic timeout;
    num_errors++;
    $display("BAD handshake expected answer seen none");
    print_verdict;
  endtask
  task automatic chk(input string n, input logic [33:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cc(input string n, input logic [7:0] e, m);
    chk(n, {26'h0, e}, {26'h0, obs & m});
  endtask
  // Bus answers are compared against the oldest noted expectation
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", exp_q.pop_front(), {s_axi_bresp, 32'h0});
    if (s_axi_rvalid && s_axi_rready)
      chk("read", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
  end
  // Single owner of the seed; scenarios pick fields from rnd
  always @(posedge aclk) begin
    rnd <= $random(seed);
    rtclock_start <= rnd[0];
  end
  task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
    int i;
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 40 && !(s_axi_bvalid && s_axi_bready); i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (i == 40) timeout;
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    int i;
    exp_q.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 40 && !(s_axi_rvalid && s_axi_rready); i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (i == 40) timeout;
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
  endtask
  task automatic pulse_wake;
    @(posedge aclk);
    wake_interrupt <= 1'b1;
    @(posedge aclk);
    wake_interrupt <= 1'b0;
    @(posedge aclk);
    #1;
  endtask
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h1;
    {s_axi_arvalid, s_axi_rready, sleep_instr, wake_interrupt} = 4'h4;
    {sleep_request_n, hw_standby_request_n, watchdog_overflow} = 3'h6;
    do_reset;
    cc("reset", 8'h01, 8'hFF);
    rd(A_SC, {OK, 32'h0});
    rd(A_S2, {OK, 32'h0});
    rd(A_CS, {OK, 32'h0});
    for (k = 0; k < 4; k++) begin
      v = rnd[15:8];
      wr(A_SC, {24'h0, v}, OK);
      rd(A_SC, {OK, 24'h0, v});
      #1 chk("stops", {28'h0, ~v[5], v[4:0]}, {28'h0, ctrl.periph_pullup_en,
        ctrl.module_clock_stop});
    end
    wr(A_SC, 32'h0, OK);
    #1 chk("resume", 34'h0, {29'h0, ctrl.module_clock_stop});
    wr(A_S2, 32'hFF, OK);
    rd(A_S2, {OK, 32'hC3});
    wr(32'hFFC00008, 32'hFF, ER);
    rd(32'hFFC00008, {ER, 32'h0});
    $display("test registers done");
    wr(A_CS, 32'h5, OK);
    wr(A_CS, 32'h2, OK);
    rd(A_CS, {OK, 32'h7});
    wr(A_CS, 32'h0, OK);
    rd(A_CS, {OK, 32'h7});
    #1 chk("clock stop", 34'h7, {31'h0, ctrl.clock_stop});
    wr(A_CC, 32'h1, OK);
    rd(A_CS, {OK, 32'h6});
    #1 chk("clock stop", 34'h6, {31'h0, ctrl.clock_stop});
    rd(A_CC, {OK, 32'h0});
    $display("test clock stop done");
    for (k = 0; k < 4; k++) begin
      wr(A_SC, {24'h0, sc_t[k]}, OK);
      wr(A_S2, {24'h0, s2_t[k]}, OK);
      sleep_instr <= 1'b1;
      @(posedge aclk);
      sleep_instr <= 1'b0;
      @(posedge aclk);
      #1 cc("mode", ob_t[k], 8'hFF);
      pulse_wake;
      cc("wake", 8'h01, 8'hFF);
    end
    @(posedge aclk);
    sleep_request_n <= 1'b0;
    repeat (2) @(posedge aclk);
    #1 cc("pin", 8'hA1, 8'hFF);
    @(posedge aclk);
    sleep_request_n <= 1'b1;
    pulse_wake;
    cc("pin wake", 8'h01, 8'hFF);
    $display("test modes done");
    wr(A_SC, 32'h3F, OK);
    watchdog_overflow <= 1'b1;
    @(posedge aclk);
    #1 cc("wdog", 8'hC0, 8'hC0);
    @(posedge aclk);
    watchdog_overflow <= 1'b0;
    rd(A_SC, {OK, 32'h0});
    rd(A_S2, {OK, 32'h0});
    $display("test watchdog done");
    wr(A_S2, 32'h40, OK);
    hw_standby_request_n <= 1'b0;
    sleep_instr <= 1'b1;
    @(posedge aclk);
    sleep_instr <= 1'b0;
    @(posedge aclk);
    #1 cc("hw", 8'h77, 8'hF7);
    chk("status oe", 34'h1, {33'h0, ctrl.proc_state_oe});
    pulse_wake;
    cc("hw wake", 8'h77, 8'hF7);
    @(posedge aclk);
    hw_standby_request_n <= 1'b1;
    do_reset;
    cc("hw reset", 8'h01, 8'hFF);
    $display("test hw standby done");
    print_verdict;
  end
endmodule
`default_nettype wire
